// >>> src/reset_watchdog_suspend_ctrl.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`include "rst_wdt_regs.svh"
module reset_watchdog_suspend_ctrl #(
   parameter int LOCK_CYC = `CYC_US(`T_LOCK_US),     // Uninterruptible part
   parameter int SEMI_CYC = `CYC_US(`T_SEMI_US),     // Semi-suspend wait
   parameter int WDT_CYC  = `CYC_US(`T_WATCH_US),    // Watchdog timeout
   parameter int WDRH_CYC = `CYC_US(`T_WDR_HOLD_US), // Watchdog reset hold
   parameter int WAKE_CYC = `CYC_US(`T_WAKE_US)      // Wake settle time
) (
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   power_good_i,
   input  wire logic                   osc_stable_i,
   input  wire logic                   usb_bus_reset_i,
   input  wire logic                   usb_activity_i,
   input  wire logic                   gpio_wake_irq_i,
   input  wire logic [7:0]             addr_i,
   input  wire logic [7:0]             wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   output logic      [7:0]             rdata_o,
   output logic                        cpu_run_o,
   output logic                        sys_rst_o,
   output logic      [13:0]            reset_pc_o,
   output logic      [7:0]             program_stack_pointer_o,
   output logic      [7:0]             data_stack_pointer_o,
   output logic                        clear_usb_addr_o,
   output logic                        int_disable_o,
   output logic                        osc_enable_o,
   output logic                        bus_reset_pending_o,
   output logic                        bus_reset_ie_o
);
   import rst_wdt_pkg::*;

   // Whole state of the block
   typedef struct packed {
      logic        pg_meta;      // Synchroniser first stage
      logic        pg_sync;      // Synchroniser second stage
      seq_state_e  state;        // Sequencer state
      logic [31:0] cnt;          // Sequencer timer
      logic [31:0] watchdog_counter; // Watchdog timer
      reg_byte_t   psc;          // Status and control
      logic        bus_ie;       // Bus reset interrupt enable
      logic        bus_pend;     // Bus reset interrupt pending
      reg_byte_t   rdata;        // Read data
      logic        run;          // CPU clocked
      logic        srst;         // Core reset
      logic        clr_addr;     // USB address clear
      logic        osc_en;       // Oscillator enable
   } st_s;

   st_s cur;   // Registered state
   st_s nxt;   // Next state

   // Full-condition for a power-on release
   logic good;
   assign good = cur.pg_sync;

   // Next-state logic
   always_comb begin
      nxt = cur;
      nxt.rdata    = 8'h00;
      nxt.clr_addr = 1'b0;
      // RULE21 synchronised release
      nxt.pg_meta = power_good_i & osc_stable_i;
      nxt.pg_sync = cur.pg_meta;
      if (cur.cnt != 32'h0) begin
         nxt.cnt = cur.cnt - 32'h1;
      end
      // Register reads
      if (rd_i) begin
         case (addr_i)
            `ADDR_PSC:    nxt.rdata = cur.psc;
            `ADDR_USB_IE: nxt.rdata = {7'h00, cur.bus_ie};
            default:      nxt.rdata = 8'h00;
         endcase
      end
      // Register writes
      if (wr_i && addr_i == `ADDR_USB_IE) begin
         nxt.bus_ie = wdata_i[`USB_IE_BUSRST];
      end
      // RULE9 restart clears watchdog
      if (wr_i && addr_i == `ADDR_WDT_RESTART) begin
         nxt.watchdog_counter = 32'h0;
      end else if (cur.state == ST_RUN) begin
         nxt.watchdog_counter = cur.watchdog_counter + 32'h1;
      end
      case (cur.state)
         // RULE5 semi-suspend while power-on held
         ST_POR: begin
            nxt.run  = 1'b0;
            nxt.srst = 1'b1;
            if (good) begin
               // RULE6 start lock period
               nxt.state = ST_LOCK;
               nxt.cnt   = 32'(LOCK_CYC - 1);
            end
         end
         ST_LOCK: begin
            if (cur.cnt == 32'h0) begin
               nxt.state = ST_SEMI;
               nxt.cnt   = 32'(SEMI_CYC - 1);
            end
         end
         ST_SEMI: begin
            // RULE7 bus reset aborts wait
            if (usb_bus_reset_i || cur.cnt == 32'h0) begin
               nxt.state = ST_RUN;
               nxt.run   = 1'b1;
               nxt.srst  = 1'b0;
               nxt.watchdog_counter = 32'h0;
            end
            // RULE8 keep bus reset pending
            if (usb_bus_reset_i) begin
               nxt.bus_pend = 1'b1;
            end
         end
         ST_RUN: begin
            if (wr_i && addr_i == `ADDR_PSC) begin
               nxt.psc = (cur.psc & ~`PSC_WR_MASK) | (wdata_i & `PSC_WR_MASK);
               // RULE15 suspend stops clocks
               if (wdata_i[`PSC_SUSPEND_BIT]) begin
                  nxt.state = ST_SLEEP;
                  nxt.run   = 1'b0;
               end
            end
            // RULE10 rollover fires reset
            if (cur.watchdog_counter >= 32'(WDT_CYC - 1)) begin
               nxt.state = ST_WDR;
               nxt.cnt   = 32'(WDRH_CYC - 1);
               nxt.run   = 1'b0;
               nxt.srst  = 1'b1;
               // RULE11 status 010X0001, RULE2 cause bit
               nxt.psc   = `PSC_WDR_VAL | (cur.psc & (8'h1 << `PSC_POR_BIT));
               // RULE13 clear USB addresses
               nxt.clr_addr = 1'b1;
               nxt.bus_ie   = 1'b0;
               nxt.bus_pend = 1'b0;
            end
         end
         // RULE12 hold watchdog reset
         ST_WDR: begin
            if (cur.cnt == 32'h0) begin
               nxt.state = ST_RUN;
               nxt.run   = 1'b1;
               nxt.srst  = 1'b0;
               nxt.watchdog_counter = 32'h0;
            end
         end
         ST_SLEEP: begin
            // RULE16 wake sources, RULE18 settle
            if (cur.cnt == 32'h0 && cur.psc[`PSC_SUSPEND_BIT]) begin
               if (gpio_wake_irq_i || usb_activity_i) begin
                  nxt.psc[`PSC_SUSPEND_BIT] = 1'b0;
                  nxt.cnt = 32'(WAKE_CYC - 1);
               end
            end else if (cur.cnt == 32'h0 && osc_stable_i) begin
               // RULE19 CPU resumes without reset
               nxt.state = ST_RUN;
               nxt.run   = cur.psc[`PSC_RUN_BIT];
            end
         end
         default: nxt.state = ST_POR;
      endcase
      // RULE1 power loss restores all defaults
      if (!good && cur.state != ST_POR) begin
         nxt.state            = ST_POR;
         nxt.psc              = `PSC_RST_VAL;
         nxt.run              = 1'b0;
         nxt.srst             = 1'b1;
         nxt.bus_ie           = 1'b0;
         nxt.bus_pend         = 1'b0;
         nxt.watchdog_counter = 32'h0;
         nxt.cnt              = 32'h0;
      end
      // Address clear stands during any core reset
      nxt.clr_addr = nxt.clr_addr | nxt.srst;
      // Oscillator stops only while suspend is in force
      nxt.osc_en = (nxt.state != ST_SLEEP) | ~nxt.psc[`PSC_SUSPEND_BIT];
   end

   // State register
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // RULE1 defaults on reset
         cur          <= '0;
         cur.state    <= ST_POR;
         cur.psc      <= `PSC_RST_VAL;
         cur.srst     <= 1'b1;
         cur.clr_addr <= 1'b1;
         cur.osc_en   <= 1'b1;
      end else begin
         cur <= nxt;
      end
   end

   // Outputs straight from flip-flops, except the constant fetch address and stack pointers
   assign rdata_o             = cur.rdata;
   assign cpu_run_o           = cur.run;
   assign sys_rst_o           = cur.srst;
   // RULE3 RULE4 fetch from zero, no push
   assign reset_pc_o          = `RESET_PC;
   assign program_stack_pointer_o = `RESET_SP;
   assign data_stack_pointer_o    = `RESET_SP;
   assign clear_usb_addr_o    = cur.clr_addr;
   assign int_disable_o       = cur.srst;
   assign osc_enable_o        = cur.osc_en;
   assign bus_reset_pending_o = cur.bus_pend;
   assign bus_reset_ie_o      = cur.bus_ie;

   // RULE10 watchdog fires on timeout
   property p_wdt_fire;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (cur.state == ST_RUN && cur.watchdog_counter >= 32'(WDT_CYC - 1) && good) |=> cur.state == ST_WDR;
   endproperty
   a_wdt_fire: assert property (p_wdt_fire) else $error("watchdog did not fire"); // RULE10
   // RULE9 restart clears counter
   property p_restart;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (wr_i && addr_i == `ADDR_WDT_RESTART) |=> cur.watchdog_counter == 32'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("restart write ignored"); // RULE9
   // RULE11 status pattern
   property p_wdr_psc;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         $rose(cur.state == ST_WDR) |-> (cur.psc & 8'hef) == `PSC_WDR_VAL;
   endproperty
   a_wdr_psc: assert property (p_wdr_psc) else $error("bad status after watchdog"); // RULE11
   // RULE13 addresses cleared
   property p_wdr_addr;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         $rose(cur.state == ST_WDR) |-> clear_usb_addr_o;
   endproperty
   a_wdr_addr: assert property (p_wdr_addr) else $error("addresses not cleared"); // RULE13
   // RULE7 abort starts CPU
   property p_abort;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (cur.state == ST_SEMI && usb_bus_reset_i && good) |=> cpu_run_o && bus_reset_pending_o;
   endproperty
   a_abort: assert property (p_abort) else $error("bus reset did not start CPU"); // RULE7
   // RULE5 CPU stopped in power-on and lock states
   property p_por_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (cur.state == ST_POR || cur.state == ST_LOCK) |-> !cpu_run_o;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("CPU ran during power-on"); // RULE5
   // RULE6 lock not interrupted
   property p_lock;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (cur.state == ST_LOCK && cur.cnt != 32'h0 && good) |=> cur.state == ST_LOCK;
   endproperty
   a_lock: assert property (p_lock) else $error("lock period broken"); // RULE6
   // RULE15 sleep keeps CPU stopped
   property p_sleep;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (cur.state == ST_SLEEP) |-> !cpu_run_o ##1 $stable(cur.watchdog_counter);
   endproperty
   a_sleep: assert property (p_sleep) else $error("activity during suspend"); // RULE15
   // Main scenarios
   c_abort: cover property (@(posedge core_clk_i) cur.state == ST_SEMI ##1 cur.state == ST_RUN);
   c_wdr:   cover property (@(posedge core_clk_i) cur.state == ST_WDR ##1 cur.state == ST_RUN);
   c_sleep: cover property (@(posedge core_clk_i) cur.state == ST_SLEEP ##1 cur.state == ST_RUN);
endmodule : reset_watchdog_suspend_ctrl

// >>> shared/rst_wdt_regs.svh
// Functional notes
// [RULE1] Any reset clears registers, addresses, stacks
// [RULE2] Status bit 4 power-on, bit 6 watchdog
// [RULE3] Fetch starts at address zero after reset
// [RULE4] Reset entry pushes nothing onto stack
// [RULE5] Power-on holds semi-suspend, CPU stopped
// [RULE6] After release: 1 ms locked, 95 ms wait
// [RULE7] Bus reset aborts semi-suspend, starts CPU
// [RULE8] Aborting bus reset leaves its interrupt pending
// [RULE9] Any restart register write clears watchdog
// [RULE10] Watchdog fires 8 ms after last clear
// [RULE11] Watchdog loads status with 010X0001
// [RULE12] Watchdog reset held 2 ms, then fetch
// [RULE13] Watchdog clears USB device addresses
// [RULE14] Firmware ignores watchdog flag when power-on set
// [RULE15] Suspend bit stops clocks and timers
// [RULE16] Only GPIO interrupt or USB activity wakes
// [RULE17] Firmware sets run with suspend bit
// [RULE18] Operational 1 ms after oscillator stable; code counts the 1 ms from the wake event, then waits for osc_stable_i
// [RULE19] Next instruction runs before pending interrupts
// [RULE20] Firmware writes 09h to FFh to suspend
// [RULE21] Power-on release from synchronised good input
`ifndef RST_WDT_REGS_SVH
`define RST_WDT_REGS_SVH
`define ADDR_WDT_RESTART 8'h26
`define ADDR_PSC         8'hff
`define ADDR_USB_IE      8'h20
`define PSC_RUN_BIT      0
`define PSC_SUSPEND_BIT  3
`define PSC_POR_BIT      4
`define PSC_WDR_BIT      6
`define PSC_RST_VAL      8'h11
`define PSC_WDR_VAL      8'h41
`define PSC_WR_MASK      8'h0d
`define USB_IE_BUSRST    0
`define RESET_PC         14'h0000
`define RESET_SP         8'h00
`define CLK_HZ           20000000
`define T_LOCK_US        1000
`define T_SEMI_US        95000
`define T_WATCH_US       8000
`define T_WDR_HOLD_US    2000
`define T_WAKE_US        1000
`define CYC_US(t)        (((t) * (`CLK_HZ / 1000000)))
`endif

// >>> shared/rst_wdt_pkg.sv
package rst_wdt_pkg;
   // Sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_POR   = 6'h01,
      ST_LOCK  = 6'h02,
      ST_SEMI  = 6'h04,
      ST_RUN   = 6'h08,
      ST_WDR   = 6'h10,
      ST_SLEEP = 6'h20
   } seq_state_e;
   typedef logic [7:0] reg_byte_t;
endpackage : rst_wdt_pkg

// >>> bench/usb_side_model.sv
`timescale 1ns/1ns
// Far side model: upstream bus and wake sources seen by the sequencer
module usb_side_model (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic bus_reset_req_i,
   input  wire logic activity_req_i,
   input  wire logic gpio_req_i,
   output logic      usb_bus_reset_o,
   output logic      usb_activity_o,
   output logic      gpio_wake_irq_o
);
   // Lines change only after a clock edge, like a real upstream driver
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         usb_bus_reset_o <= 1'b0;
         usb_activity_o  <= 1'b0;
         gpio_wake_irq_o <= 1'b0;
      end else begin
         usb_bus_reset_o <= bus_reset_req_i;
         usb_activity_o  <= activity_req_i;
         gpio_wake_irq_o <= gpio_req_i;
      end
   end
endmodule : usb_side_model

// >>> bench/reset_watchdog_suspend_ctrl_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module reset_watchdog_suspend_ctrl_tb;
   import rst_wdt_pkg::*;
   localparam int LOCK = 20;   // Shortened counts
   localparam int SEMI = 40;
   localparam int WDT  = 30;
   localparam int WDRH = 20;
   localparam int WAKE = 20;
   logic core_clk_i = 1'b0, rst_n_i = 1'b0, pg = 1'b0, os = 1'b0;
   logic brq = 1'b0, arq = 1'b0, grq = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rv;
   logic busrst, act, gpio;
   logic [7:0] rdata_o, program_stack_pointer, dsp;
   logic [13:0] pc;
   logic cpu_run_o, sys_rst_o, clr_o, intd_o, osc_o, pend_o, ie_o;
   int mismatches = 0, n_tests = 0, n, mdl_status, d;
   // Free running clock
   always #25 core_clk_i = ~core_clk_i;
   usb_side_model usb_side_model_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus_reset_req_i(brq),
      .activity_req_i(arq), .gpio_req_i(grq), .usb_bus_reset_o(busrst), .usb_activity_o(act),
      .gpio_wake_irq_o(gpio));
   reset_watchdog_suspend_ctrl #(.LOCK_CYC(LOCK), .SEMI_CYC(SEMI), .WDT_CYC(WDT), .WDRH_CYC(WDRH),
      .WAKE_CYC(WAKE)) reset_watchdog_suspend_ctrl_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .power_good_i(pg), .osc_stable_i(os), .usb_bus_reset_i(busrst), .usb_activity_i(act),
      .gpio_wake_irq_i(gpio), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o),
      .cpu_run_o(cpu_run_o), .sys_rst_o(sys_rst_o), .reset_pc_o(pc), .program_stack_pointer_o(program_stack_pointer),
      .data_stack_pointer_o(dsp), .clear_usb_addr_o(clr_o), .int_disable_o(intd_o), .osc_enable_o(osc_o),
      .bus_reset_pending_o(pend_o), .bus_reset_ie_o(ie_o));
   // One cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge core_clk_i);
      wr    <= 1'b0;
   endtask : wr_reg
   // Read; data sampled in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk_i);
      rd   <= 1'b0;
      #1 v = rdata_o;
   endtask : rd_reg
   // Bounded wait on run (sel 0) or core reset (sel 1)
   task automatic wait_lvl(input int sel, input logic lvl, output int cnt);
      cnt = 0;
      while (((sel == 0) ? cpu_run_o : sys_rst_o) !== lvl && cnt < 2000) begin
         @(posedge core_clk_i);
         #1 cnt++;
      end
   endtask : wait_lvl
   task automatic kick();
      wr_reg(8'h26, 8'($urandom));
   endtask : kick
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   // Watchdog on the whole run
   initial begin
      #2000000;
      mismatches++;
      conclude();
   end
   // Main sequence
   initial begin
      void'($urandom(71270));
      repeat (2) @(posedge core_clk_i);
      #1;
      `CHK({sys_rst_o, cpu_run_o, intd_o, clr_o}, 4'b1011)
      `CHK({pc, program_stack_pointer, dsp}, 30'h0)
      @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      os <= 1'b1;
      repeat (10) @(posedge core_clk_i);
      `CHK(cpu_run_o, 1'b0)
      pg <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      brq <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      brq <= 1'b0;
      #1;
      `CHK({cpu_run_o, osc_o}, 2'b01)
      wait_lvl(0, 1'b1, n);
      `CHK((n + 8 >= LOCK + SEMI) && (n + 8 <= LOCK + SEMI + 6), 1'b1)
      kick();
      mdl_status = 8'h11;
      rd_reg(8'hff, rv);
      `CHK(rv, 8'(mdl_status))
      rd_reg(8'h55, rv);
      `CHK(rv, 8'h00)
      d = ($urandom & 8'hf7) | 8'h01;
      wr_reg(8'hff, 8'(d));
      mdl_status = (mdl_status & 8'hf2) | (d & 8'h0d);
      rd_reg(8'hff, rv);
      `CHK(rv, 8'(mdl_status))
      kick();
      for (int i = 0; i < 4; i++) begin
         repeat (WDT - 5) @(posedge core_clk_i);
         kick();
         `CHK(sys_rst_o, 1'b0)
      end
      wait_lvl(1, 1'b1, n);
      `CHK((n >= WDT - 4) && (n <= WDT + 2), 1'b1)
      `CHK({clr_o, cpu_run_o}, 2'b10)
      wait_lvl(1, 1'b0, n);
      `CHK((n >= WDRH - 2) && (n <= WDRH + 2), 1'b1)
      wait_lvl(0, 1'b1, n);
      `CHK((n <= 3) && (pc === 14'h0000), 1'b1)
      mdl_status = 8'h41 | (mdl_status & 8'h10);
      rd_reg(8'hff, rv);
      `CHK(rv, 8'(mdl_status))
      wr_reg(8'h20, 8'h01);
      #1;
      `CHK(ie_o, 1'b1)
      pg <= 1'b0;
      repeat (5) @(posedge core_clk_i);
      pg <= 1'b1;
      #1;
      `CHK(ie_o, 1'b0)
      repeat (LOCK + 10) @(posedge core_clk_i);
      brq <= 1'b1;
      wait_lvl(0, 1'b1, n);
      brq <= 1'b0;
      `CHK((n <= 6) && (pend_o === 1'b1), 1'b1)
      kick();
      rd_reg(8'hff, rv);
      `CHK(rv, 8'h11)
      for (int i = 0; i < 2; i++) begin
         kick();
         wr_reg(8'hff, 8'h09);
         @(posedge core_clk_i);
         #1;
         `CHK({osc_o, cpu_run_o}, 2'b00)
         repeat (WDT + 10) @(posedge core_clk_i);
         `CHK({sys_rst_o, cpu_run_o}, 2'b00)
         arq <= (i == 0);
         grq <= (i == 1);
         wait_lvl(0, 1'b1, n);
         arq <= 1'b0;
         grq <= 1'b0;
         `CHK((n >= WAKE) && (n <= WAKE + 5) && (osc_o === 1'b1), 1'b1)
      end
      kick();
      conclude();
   end
endmodule : reset_watchdog_suspend_ctrl_tb
